/* hdl/dosd_pkg.sv */
// Package with timing constants and types for the dual one-shot delay
package dosd_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int TRIG_MIN_NS = 50;
    localparam int TRIG_MIN_CYC = (TRIG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Range bases in ns: 50 ns, 500 ns, 5 us, 50 us, 500 us
    localparam int RANGE_BASE_NS [5] = '{50, 500, 5000, 50000, 500000};
    localparam int RANGE_SPAN = 15;
    localparam int FINE_W = 4;
    localparam int RANGE_W = 3;
    localparam int RANGE_COUNT = 5;
    localparam int RECOV_MIN_NS = 30;
    localparam int RECOV_FACTOR = 300;
    localparam int CNT_W = 20;
    localparam logic [CNT_W-1:0] CNT_ZERO = 20'h00000;
    localparam logic [CNT_W-1:0] CNT_ONE = 20'h00001;

    typedef enum logic [1:0] {
        DOSD_IDLE = 2'b00,
        DOSD_ACTIVE = 2'b01,
        DOSD_RECOVER = 2'b11
    } dosd_state_t;

    typedef struct packed {
        logic [RANGE_W-1:0] range;
        logic [FINE_W-1:0] fine;
        logic fine_sel;
    } dosd_cfg_t;
endpackage

/* hdl/dosd_top.sv */
// Dual non-retriggerable one-shot delay with range and fine settings
`timescale 1ns/1ps
// Functional notes
// - Two independent channels, each with own trigger, settings and output.
// - Fire once the trigger has been low for 50 ns; shorter low pulses do not fire.
// - Fired output goes high for the configured time, then low.
// - Delay spans 50 ns to 7.5 ms over the ranges.
// - Five decade ranges from 50-750 ns up to 0.5-7.5 ms.
// - Fine setting steps the delay within the chosen range.
// - Recovery after output falls: 30 ns minimum, scaled with range.
// - Without fine element selected, output stays high until it is selected or reset.
module dosd_top #(
    parameter int CHANNELS = 2
) (
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic [CHANNELS-1:0] trig_n_in,
    input dosd_pkg::dosd_cfg_t [CHANNELS-1:0] cfg_in,
    output logic [CHANNELS-1:0] pulse_out,
    output logic [CHANNELS-1:0] ready_out
);
    import dosd_pkg::*;

    // Largest counts the channel counter must hold
    localparam int MAX_DELAY_CYC = (RANGE_BASE_NS[RANGE_COUNT-1] / CLK_PERIOD_NS) * RANGE_SPAN;
    localparam int MAX_RECOV_CYC = (RECOV_MIN_NS * (RANGE_BASE_NS[RANGE_COUNT-1] / RANGE_BASE_NS[0])
        + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Elaboration checks on sizes the logic relies on
    if (CHANNELS < 1) begin : g_chk_channels
        $error("CHANNELS must be at least 1");
    end
    if (RANGE_COUNT > (1 << RANGE_W)) begin : g_chk_range
        $error("RANGE_W cannot encode every range");
    end
    if (RANGE_SPAN > (1 << FINE_W) - 1) begin : g_chk_fine
        $error("FINE_W cannot encode the fine span");
    end
    if (MAX_DELAY_CYC >= (1 << CNT_W) || MAX_RECOV_CYC >= (1 << CNT_W)) begin : g_chk_count
        $error("CNT_W too narrow for the longest delay or recovery");
    end

    for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
        dosd_channel #(
            .TRIG_CYC(TRIG_MIN_CYC)
        ) u_dosd_channel (
            .mclk_in(mclk_in),
            .resetn_in(resetn_in),
            .trig_n_in(trig_n_in[c]),
            .cfg_in(cfg_in[c]),
            .pulse_out(pulse_out[c]),
            .ready_out(ready_out[c])
        );
    end
endmodule

// One non-retriggerable delay channel
module dosd_channel #(
    parameter int TRIG_CYC = dosd_pkg::TRIG_MIN_CYC
) (
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic trig_n_in,
    input dosd_pkg::dosd_cfg_t cfg_in,
    output logic pulse_out,
    output logic ready_out
);
    import dosd_pkg::*;

    localparam int LOW_W = $clog2(TRIG_CYC + 1);
    localparam logic [LOW_W-1:0] LOW_LAST = LOW_W'(TRIG_CYC - 1);

    if (TRIG_CYC < 1) begin : g_chk_trig
        $error("TRIG_CYC must be at least 1");
    end

    // Cycles per fine step in each range
    function automatic logic [CNT_W-1:0] step_cyc(input logic [RANGE_W-1:0] r);
        int v;
        v = RANGE_BASE_NS[0] / CLK_PERIOD_NS;
        for (int i = 0; i < RANGE_COUNT; i++) begin
            if (r == RANGE_W'(i)) begin
                v = RANGE_BASE_NS[i] / CLK_PERIOD_NS;
            end
        end
        return CNT_W'(v);
    endfunction

    // Recovery cycles: minimum scaled by the same decade as the range
    function automatic logic [CNT_W-1:0] recov_cyc(input logic [RANGE_W-1:0] r);
        int v;
        v = (RECOV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        for (int i = 0; i < RANGE_COUNT; i++) begin
            if (r == RANGE_W'(i)) begin
                v = (RECOV_MIN_NS * (RANGE_BASE_NS[i] / RANGE_BASE_NS[0]) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
            end
        end
        return CNT_W'(v);
    endfunction

    logic sync1_reg, sync1_next;
    logic sync2_reg, sync2_next;
    logic [LOW_W-1:0] low_cnt_reg, low_cnt_next;
    logic armed_reg, armed_next;
    dosd_state_t state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic out_reg, out_next;
    logic fire;
    logic [FINE_W-1:0] fine_mult;
    logic [CNT_W-1:0] delay_load;
    logic [CNT_W-1:0] recov_load;

    // Two-stage synchroniser, reset to the idle high level
    always_comb begin
        sync1_next = trig_n_in;
        sync2_next = sync1_reg;
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
        end
    end

    // Fire once the low level has lasted the minimum, one fire per low
    always_comb begin
        low_cnt_next = low_cnt_reg;
        armed_next = armed_reg;
        fire = 1'b0;
        if (sync2_reg) begin
            low_cnt_next = '0;
            armed_next = 1'b1;
        end else if (armed_reg) begin
            if (low_cnt_reg == LOW_LAST) begin
                fire = 1'b1;
                armed_next = 1'b0;
            end else begin
                low_cnt_next = low_cnt_reg + LOW_W'(1);
            end
        end
    end

    // Fine setting zero counts as one step
    always_comb begin
        fine_mult = (cfg_in.fine == '0) ? FINE_W'(1) : cfg_in.fine;
        delay_load = CNT_W'(step_cyc(cfg_in.range) * CNT_W'(fine_mult));
        recov_load = recov_cyc(cfg_in.range);
    end

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        out_next = out_reg;
        case (state_reg)
            DOSD_IDLE: begin
                if (fire) begin
                    state_next = DOSD_ACTIVE;
                    out_next = 1'b1;
                    cnt_next = delay_load;
                end
            end
            DOSD_ACTIVE: begin
                // Fine element missing: count frozen, output held high
                if (!cfg_in.fine_sel) begin
                    cnt_next = cnt_reg;
                end else if (cnt_reg <= CNT_ONE) begin
                    state_next = DOSD_RECOVER;
                    out_next = 1'b0;
                    cnt_next = recov_load;
                end else begin
                    cnt_next = cnt_reg - CNT_ONE;
                end
            end
            DOSD_RECOVER: begin
                // Recovery counts only while trigger stays high
                if (!sync2_reg) begin
                    cnt_next = recov_load;
                end else if (cnt_reg <= CNT_ONE) begin
                    state_next = DOSD_IDLE;
                    cnt_next = CNT_ZERO;
                end else begin
                    cnt_next = cnt_reg - CNT_ONE;
                end
            end
            default: begin
                state_next = DOSD_IDLE;
                cnt_next = CNT_ZERO;
                out_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            low_cnt_reg <= '0;
            armed_reg <= 1'b0;
            state_reg <= DOSD_IDLE;
            cnt_reg <= CNT_ZERO;
            out_reg <= 1'b0;
        end else begin
            low_cnt_reg <= low_cnt_next;
            armed_reg <= armed_next;
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            out_reg <= out_next;
        end
    end

    assign pulse_out = out_reg;
    assign ready_out = (state_reg == DOSD_IDLE);
endmodule

/* bench/dosd_trig_src.sv */
// Trigger source that holds each trigger low for five clocks
`timescale 1ns/1ps
module dosd_trig_src (
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic [1:0] go_in,
    output logic [1:0] trig_n_out
);
    logic [2:0] low_reg [2];
    logic [2:0] low_next [2];
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            low_next[i] = (low_reg[i] != 3'h0) ? low_reg[i] - 3'h1 : (go_in[i] ? 3'h5 : 3'h0);
            trig_n_out[i] = (low_reg[i] == 3'h0);
        end
    end
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) low_reg <= '{3'h0, 3'h0};
        else low_reg <= low_next;
    end
endmodule

/* bench/dosd_checker.sv */
// Assertions on the one-shot ports
`timescale 1ns/1ps
module dosd_checker import dosd_pkg::*; #(
    parameter int CHANNELS = 2
) (
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic [CHANNELS-1:0] trig_n_in,
    input dosd_pkg::dosd_cfg_t [CHANNELS-1:0] cfg_in,
    input wire logic [CHANNELS-1:0] pulse_out,
    input wire logic [CHANNELS-1:0] ready_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);
    busy_excl_a: assert property ((pulse_out & ready_out) == '0) else $error("pulse while ready");
    fire_lat_a: assert property (
        (ready_out[0] && trig_n_in[0] ##1 !trig_n_in[0] [*5]) |-> ##[1:4] pulse_out[0]) else $error("no fire");
    rise_cause0_a: assert property (
        $rose(pulse_out[0]) |-> $past(ready_out[0]) && !$past(trig_n_in[0], 4)) else $error("bad rise 0");
    rise_cause1_a: assert property (
        $rose(pulse_out[1]) |-> $past(ready_out[1]) && !$past(trig_n_in[1], 4)) else $error("bad rise 1");
    pulse_width_a: assert property (
        $rose(pulse_out[0]) && cfg_in[0] == 8'h03 |-> pulse_out[0] [*5] ##1 !pulse_out[0]) else $error("bad width");
    stuck_high_a: assert property (pulse_out[0] && !cfg_in[0].fine_sel |=> pulse_out[0]) else $error("fell");
    recov_time_a: assert property (
        $fell(pulse_out[0]) && cfg_in[0].range == 3'h0 && trig_n_in[0]
        |-> !ready_out[0] [*3] ##[1:3] ready_out[0]) else $error("bad recovery");
    ready_drop_a: assert property ($fell(ready_out[0]) |-> $rose(pulse_out[0])) else $error("bad drop");
    cover property ($rose(pulse_out[0]));
    cover property (pulse_out[0] && !cfg_in[0].fine_sel);
    cover property ($rose(pulse_out[1]));
    cover property ($rose(ready_out[0]));
endmodule
bind dosd_top dosd_checker #(.CHANNELS(CHANNELS)) u_dosd_checker (.mclk_in(mclk_in), .resetn_in(resetn_in),
    .trig_n_in(trig_n_in), .cfg_in(cfg_in), .pulse_out(pulse_out), .ready_out(ready_out));

/* bench/dosd_top_tb.sv */
// Self-checking bench for the dual one-shot delay
`timescale 1ns/1ps
module dosd_top_tb;
    import dosd_pkg::*;
    logic mclk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [1:0] go = 2'b00;
    logic [1:0] trig_n;
    dosd_cfg_t [1:0] cfg = '0;
    logic [1:0] pulse;
    logic [1:0] ready;
    int n_mismatch = 0;
    int cmp_count = 0;
    always #5 mclk_in = ~mclk_in;
    dosd_trig_src u_dosd_trig_src (.mclk_in(mclk_in), .resetn_in(resetn_in), .go_in(go), .trig_n_out(trig_n));
    dosd_top u_dosd_top (.mclk_in(mclk_in), .resetn_in(resetn_in), .trig_n_in(trig_n), .cfg_in(cfg),
        .pulse_out(pulse), .ready_out(ready));
    task automatic check(string name, logic [31:0] exp, logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %0d seen %0d", name, exp, got);
        end
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic do_reset();
        @(posedge mclk_in);
        resetn_in <= 1'b0;
        repeat (16) @(posedge mclk_in);
        check("pulse", 2'b00, pulse);
        check("ready", 2'b11, ready);
        resetn_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
    endtask
    task automatic fire_pair(dosd_cfg_t c0, dosd_cfg_t c1, int w0, int w1, int again);
        int hi [2];
        int rises [2];
        logic [1:0] prev;
        hi = '{0, 0};
        rises = '{0, 0};
        prev = 2'b00;
        @(posedge mclk_in);
        cfg <= {c1, c0};
        go <= 2'b11;
        for (int t = 1; t < 9000; t++) begin
            @(posedge mclk_in);
            go <= (t == again) ? 2'b11 : 2'b00;
            #1;
            for (int i = 0; i < 2; i++) begin
                hi[i] += pulse[i];
                rises[i] += (pulse[i] && !prev[i]);
            end
            prev = pulse;
            if (t > 20 && ready === 2'b11) break;
        end
        check("width0", w0, hi[0]);
        check("width1", w1, hi[1]);
        check("rises0", 1, rises[0]);
        check("rises1", 1, rises[1]);
        check("ready", 2'b11, ready);
        if (ready !== 2'b11) close_out();
    endtask
    task automatic hold_test();
        @(posedge mclk_in);
        cfg <= {8'h03, 8'h02};
        go <= 2'b01;
        @(posedge mclk_in);
        go <= 2'b00;
        repeat (300) @(posedge mclk_in);
        #1;
        check("held", 1, pulse[0]);
        do_reset();
    endtask
    initial begin
        do_reset();
        fire_pair(8'h03, 8'h3F, 5, 750, 0);
        fire_pair(8'h1F, 8'h43, 75, 500, 40);
        fire_pair(8'h01, 8'h63, 5, 5000, 0);
        hold_test();
        close_out();
    end
endmodule
